// ==== bench/bcg_clkgen_chk.sv ====
module bcg_clkgen_chk #(
    parameter int BAUD_DIV = 16
) (
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Power-up reset
    input wire logic e_clk, // Enable clock
    input wire logic phi1, // Phase one
    input wire logic phi2, // Phase two
    input wire logic [15:0] addr_o, // Address bus
    input wire logic rw_o, // High is read
    input wire logic data_oe, // Data drive enable
    input wire logic cycle_start, // New cycle pulse
    input wire logic cpu_reset, // Core reset
    input wire logic timer_tick, // Timer pulse
    input wire logic baud_tick // Bit-rate pulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Enable edges that every bus step hangs on
    sequence s_rise; $rose(e_clk); endsequence
    sequence s_fall; $fell(e_clk); endsequence
    a_phase_two_e: assert property (phi2 == e_clk) else $error("phi2 off e_clk");
    a_phase_no_overlap: assert property (!(phi1 && phi2)) else $error("phases overlap");
    a_high_half_len: assert property (s_rise |-> ##16 s_fall) else $error("high half");
    a_low_half_len: assert property (s_fall |-> ##16 s_rise) else $error("low half");
    a_addr_held: assert property (!$fell(e_clk) |-> $stable(addr_o) && $stable(rw_o))
        else $error("address moved mid cycle");
    a_drive_high_only: assert property (data_oe |-> e_clk && !rw_o) else $error("bad drive");
    a_write_drives: assert property (s_rise |-> rw_o || data_oe) else $error("no drive");
    a_cycle_start_after: assert property (s_fall |-> cycle_start ##1 !cycle_start)
        else $error("no start");
    a_phase_one_gap: assert property (s_fall |-> !phi1 ##1 phi1)
        else $error("phase one timing");
    a_reset_idle_read: assert property (cpu_reset |-> rw_o && addr_o == 16'hFFFF)
        else $error("bus active in reset");
    a_timer_per_e: assert property (s_rise |-> timer_tick ##1 !timer_tick)
        else $error("timer tick");
    a_reset_on_fall: assert property ($changed(cpu_reset) |-> $fell(e_clk))
        else $error("reset off E fall");
    // Timer ticks since the last bit-rate tick
    int tick_cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 0;
        end else if (baud_tick) begin
            tick_cnt <= 0;
        end else if (timer_tick) begin
            tick_cnt <= tick_cnt + 1;
        end
    end
    a_baud_period: assert property (baud_tick |-> tick_cnt == BAUD_DIV)
        else $error("baud period");
endmodule // bcg_clkgen_chk

bind bcg_clkgen bcg_clkgen_chk #(.BAUD_DIV(BAUD_DIV)) i_bcg_clkgen_chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .e_clk(e_clk), .phi1(phi1), .phi2(phi2), .addr_o(addr_o), .rw_o(rw_o),
    .data_oe(data_oe), .cycle_start(cycle_start), .cpu_reset(cpu_reset),
    .timer_tick(timer_tick), .baud_tick(baud_tick));

// ==== bench/bcg_clkgen_tb.sv ====
module bcg_clkgen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BD = 4;
    logic sys_clk = 0, rst_n = 0, reset_in_n = 0, cpu_valid = 0, cpu_rw = 1, cpu_rmw = 0;
    logic [2:0] osc = 3'h0;
    logic [15:0] cpu_addr = 16'h0000, addr_o, ecycle_count;
    logic [7:0] cpu_wdata = 8'h00, data_i, data_o, rdata;
    logic e_clk, phi1, phi2, rw_o, data_oe, cycle_start, rdata_valid, cpu_reset;
    logic timer_tick, baud_tick;
    int err_count = 0, compares = 0;
    wire [4:0] ev = {!cpu_reset, baud_tick, timer_tick, rdata_valid, cycle_start};
    always #2.5 sys_clk = ~sys_clk;
    // Steady outside clock, never stretched; halves of 4 cycles clear the sync limit
    always @(posedge sys_clk) osc <= #1 osc + 3'h1;
    bcg_clkgen #(.BAUD_DIV(BD)) i_bcg_clkgen (.sys_clk(sys_clk), .rst_n(rst_n),
        .crystal_input_a(1'b0), .crystal_input_b(osc[2]), .reset_in_n(reset_in_n),
        .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_rw(cpu_rw), .cpu_rmw(cpu_rmw),
        .cpu_wdata(cpu_wdata), .data_i(data_i), .e_clk(e_clk), .phi1(phi1), .phi2(phi2),
        .addr_o(addr_o), .rw_o(rw_o), .data_o(data_o), .data_oe(data_oe),
        .cycle_start(cycle_start), .rdata(rdata), .rdata_valid(rdata_valid),
        .cpu_reset(cpu_reset), .timer_tick(timer_tick), .baud_tick(baud_tick),
        .ecycle_count(ecycle_count));
    bcg_mem_model i_bcg_mem_model (.sys_clk(sys_clk), .e_clk(e_clk), .addr_o(addr_o),
        .rw_o(rw_o), .data_o(data_o), .data_oe(data_oe), .data_i(data_i));
    task automatic test_done;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Bounded wait for one event; n returns the cycles taken
    task automatic wt(int sel, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (n < 400 && ev[sel] !== 1'b1);
        chk("event", 16'h0001, {15'h0000, ev[sel]});
    endtask
    // Request levels set right after a cycle began, checked at the next one
    task automatic bus(logic [15:0] a, logic rd, logic rmw, logic [7:0] wd);
        int n;
        wt(0, n);
        cpu_addr = a;
        cpu_rw = rd;
        cpu_rmw = rmw;
        cpu_wdata = wd;
        cpu_valid = 1'b1;
        wt(0, n);
        chk("addr_o", a, addr_o);
        chk("rw_o", {15'h0000, rd}, {15'h0000, rw_o});
        cpu_valid = 1'b0;
    endtask
    task automatic t_reset;
        int n;
        n = 0;
        repeat (128) begin
            tick(1);
            n += timer_tick;
        end
        chk("e_rises", 16'h0004, 16'(n));
        chk("cpu_reset", 16'h0001, {15'h0000, cpu_reset});
        chk("idle_addr", 16'hFFFF, addr_o);
        reset_in_n = 1'b1;
        wt(4, n);
        chk("e_at_release", 16'h0000, {15'h0000, e_clk});
    endtask
    task automatic t_div;
        int n;
        logic [15:0] c0;
        wt(2, n);
        c0 = ecycle_count;
        wt(2, n);
        chk("e_period", 16'h0020, 16'(n));
        chk("e_count", c0 + 16'h0001, ecycle_count);
    endtask
    task automatic t_bus;
        int n;
        bus(16'h0003, 1'b0, 1'b0, 8'hA5);
        bus(16'h0003, 1'b1, 1'b0, 8'h00);
        wt(1, n);
        chk("read_back", 16'h00A5, {8'h00, rdata});
        bus(16'h0007, 1'b1, 1'b1, 8'h3C);
        wt(0, n);
        chk("rmw_read", 16'h0077, {8'h00, rdata});
        chk("rmw_rw", 16'h0000, {15'h0000, rw_o});
        chk("rmw_addr", 16'h0007, addr_o);
        bus(16'h0007, 1'b1, 1'b0, 8'h00);
        wt(1, n);
        chk("rmw_data", 16'h003C, {8'h00, rdata});
    endtask
    task automatic t_baud;
        int n;
        wt(3, n);
        wt(3, n);
        chk("baud_gap", 16'h0080, 16'(n));
    endtask
    // Main sequence
    initial begin
        tick(10);
        rst_n = 1'b1;
        t_reset;
        t_div;
        t_bus;
        t_baud;
        test_done;
    end
    // Watchdog, well beyond the few microseconds the run needs
    initial begin
        #20000;
        err_count++;
        test_done;
    end
endmodule // bcg_clkgen_tb

// ==== bench/bcg_mem_model.sv ====
module bcg_mem_model (
    input wire logic sys_clk, // System clock
    input wire logic e_clk, // Enable clock
    input wire logic [15:0] addr_o, // Address bus
    input wire logic rw_o, // High is read
    input wire logic [7:0] data_o, // Device write data
    input wire logic data_oe, // Device drives
    output logic [7:0] data_i // Bus level to device
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];
    // Small memory, pattern so reads differ
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'(i * 17);
        data_i = 8'h5A;
    end
    // Bus only in the high half of a read; off the bus it keeps flipping
    always @(posedge sys_clk) begin
        if (e_clk && rw_o) begin
            data_i <= #1 mem[addr_o[3:0]];
        end else begin
            data_i <= #1 ~data_i;
        end
        if (data_oe && e_clk) mem[addr_o[3:0]] <= data_o;
    end
endmodule // bcg_mem_model

// ==== rtl/bcg_baud.sv ====
`include "bcg_cfg.svh"
module bcg_baud #(
    parameter int BAUD_DIV = `BCG_BAUD_DIV
) (
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    bcg_tick_if.baud tk // Timer tick in, baud tick out
);
    localparam int CW = $clog2(BAUD_DIV);

    // A divider below two leaves no count to wrap
    if (BAUD_DIV < 2) begin : g_bad_div
        $error("BAUD_DIV must be at least 2");
    end

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic wrap;

    // Counts timer ticks only, so a stretched input clock slows serial timing too
    assign wrap = (count == CW'(BAUD_DIV - 1));
    assign next_count = wrap ? '0 : count + CW'(1);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tk.baud_tick <= 1'b0;
        end else begin
            tk.baud_tick <= tk.timer_tick & wrap;
            if (tk.timer_tick) begin
                count <= next_count;
            end
        end
    end
endmodule // bcg_baud

// ==== rtl/bcg_cfg.svh ====
// Functional notes
// - The bus enable clock runs at one quarter of the oscillator input frequency.
// - Two non-overlapping internal phases come from the enable, phase two in step with it.
// - Each enable edge is made on every second falling edge of the input clock.
// - A bus cycle is one low half of the enable followed by one high half.
// - The address is valid in the low half and data moves in the following high half.
// - Data is driven on the data bus only while the enable is high, by any party.
// - Cycle-based timing of the device is counted in enable clock cycles.
// - The read/write line is high for a read and low for a write; read-modify-write does both.
// - The timer is clocked by the enable, so it follows any change of the input clock.
// - The serial bit rate generator is clocked from the timer.
// - The enable keeps running while the reset pin is held low.
// - The reset pin is synchronised to the enable and taken on an enable falling edge.
`ifndef BCG_CFG_SVH
`define BCG_CFG_SVH
`define BCG_PHASE_W 2
`define BCG_PHASE_RST 2'h0
`define BCG_PHASE_STEP 2'h1
`define BCG_E_BIT 1
`define BCG_IDLE_ADDR 16'hFFFF
`define BCG_ADDR_W 16
`define BCG_DATA_W 8
`define BCG_BAUD_DIV 16
`define BCG_ECNT_W 16
`endif

// ==== rtl/bcg_clkgen.sv ====
`include "bcg_cfg.svh"
module bcg_clkgen #(
    parameter int BAUD_DIV = `BCG_BAUD_DIV
) (
    input wire logic sys_clk, // System clock, 200 MHz
    input wire logic rst_n, // Power-up reset, asynchronous, active low
    input wire logic crystal_input_a, // Oscillator pin, grounded with an outside source
    input wire logic crystal_input_b, // Oscillator pin, outside clock source
    input wire logic reset_in_n, // Reset pin, active low
    input wire logic cpu_valid, // Core has a bus request
    input wire logic [15:0] cpu_addr, // Request address
    input wire logic cpu_rw, // Request direction, high is read
    input wire logic cpu_rmw, // Read to be followed by a write
    input wire logic [7:0] cpu_wdata, // Write data
    input wire logic [7:0] data_i, // Data bus pin level
    output logic e_clk, // Bus enable clock
    output logic phi1, // Internal phase one
    output logic phi2, // Internal phase two
    output logic [15:0] addr_o, // Address bus
    output logic rw_o, // Read/write line
    output logic [7:0] data_o, // Data bus drive value
    output logic data_oe, // Data bus drive enable
    output logic cycle_start, // Pulse: a new bus cycle began
    output logic [7:0] rdata, // Read data of the last cycle
    output logic rdata_valid, // Pulse: rdata updated
    output logic cpu_reset, // Reset as seen by the core
    output logic timer_tick, // Pulse per enable cycle
    output logic baud_tick, // Pulse per bit-rate period
    output logic [15:0] ecycle_count // Free count of enable cycles
);
    // Bus widths are fixed by the port list; other macro values would cut bits
    if (`BCG_ADDR_W != 16 || `BCG_DATA_W != 8) begin : g_bad_width
        $error("Bus widths must be 16 and 8");
    end

    // The bit-rate divider cannot wrap in fewer than two timer ticks
    if (BAUD_DIV < 2) begin : g_bad_div
        $error("BAUD_DIV must be at least 2");
    end

    bcg_tick_if tk ();

    // Each oscillator pin passes two flops of its own before the XOR, so a glitch
    // of the XOR never reaches a first stage; s1 is read only by s2
    logic xa_s1;
    logic xa_s2;
    logic xb_s1;
    logic xb_s2;
    logic osc_s2;
    logic osc_s3;
    logic rst_s1;
    logic rst_s2;
    logic [7:0] din_s1;
    logic [7:0] din_s2;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xa_s1 <= 1'b0;
            xa_s2 <= 1'b0;
            xb_s1 <= 1'b0;
            xb_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
            din_s1 <= 8'h00;
            din_s2 <= 8'h00;
        end else begin
            xa_s1 <= crystal_input_a;
            xa_s2 <= xa_s1;
            xb_s1 <= crystal_input_b;
            xb_s2 <= xb_s1;
            osc_s3 <= osc_s2;
            rst_s1 <= reset_in_n;
            rst_s2 <= rst_s1;
            din_s1 <= data_i;
            din_s2 <= din_s1;
        end
    end

    // Oscillator level as the two synchronised pins give it
    assign osc_s2 = xa_s2 ^ xb_s2;

    // Divider works on falling edges only, so input duty cycle does not matter
    logic osc_fall;
    logic [`BCG_PHASE_W-1:0] phase;
    logic [`BCG_PHASE_W-1:0] next_phase;
    logic next_e;
    logic e_falls;
    logic e_rises;
    logic next_phi1;

    // Phase counts oscillator falls: 0 and 1 keep E low, 2 and 3 keep it high
    assign osc_fall = osc_s3 & ~osc_s2;
    assign next_phase = osc_fall ? phase + `BCG_PHASE_STEP : phase;
    assign next_e = next_phase[`BCG_E_BIT];
    // Edge strobes look one cycle ahead, so registered outputs move with E
    assign e_falls = e_clk & ~next_e;
    assign e_rises = ~e_clk & next_e;
    // Phase one waits a cycle after E falls, so the two phases never overlap
    assign next_phi1 = ~next_e & ~e_clk;

    // A stretched half just delays the next falling edge; the phase stays in step
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= `BCG_PHASE_RST;
            e_clk <= 1'b0;
            phi1 <= 1'b0;
            phi2 <= 1'b0;
        end else begin
            phase <= next_phase;
            e_clk <= next_e;
            phi1 <= next_phi1;
            phi2 <= next_e;
        end
    end

    // Bus sequencer: a new cycle starts as E falls; idle cycles read the top address
    bcg_pkg::bcg_seq_t seq;
    bcg_pkg::bcg_seq_t next_seq;
    logic [15:0] hold_addr;
    logic [15:0] next_addr;
    logic next_rw;
    logic [7:0] next_wdata;
    logic next_oe;
    logic [7:0] wdata;
    logic take_reset;
    bcg_pkg::bcg_seq_t start_seq;
    logic [15:0] start_addr;
    logic start_rw;

    assign next_seq = (seq == bcg_pkg::BCG_RMW_WR) ? bcg_pkg::BCG_NORMAL
                    : ((cpu_valid & cpu_rw & cpu_rmw) ? bcg_pkg::BCG_RMW_WR
                                                      : bcg_pkg::BCG_NORMAL);
    assign next_addr = (seq == bcg_pkg::BCG_RMW_WR) ? hold_addr
                     : (cpu_valid ? cpu_addr : `BCG_IDLE_ADDR);
    assign next_rw = (seq == bcg_pkg::BCG_RMW_WR) ? 1'b0
                   : (cpu_valid ? cpu_rw : 1'b1);
    assign next_wdata = cpu_wdata;
    // The reset taken at an E fall also makes the cycle it starts an idle read
    assign take_reset = ~rst_s2;
    assign start_seq = take_reset ? bcg_pkg::BCG_NORMAL : next_seq;
    assign start_addr = take_reset ? `BCG_IDLE_ADDR : next_addr;
    assign start_rw = take_reset ? 1'b1 : next_rw;
    // Only writes drive, and only in the high half of E
    assign next_oe = next_e & ~rw_o & ~cpu_reset;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq <= bcg_pkg::BCG_NORMAL;
            hold_addr <= `BCG_IDLE_ADDR;
            addr_o <= `BCG_IDLE_ADDR;
            rw_o <= 1'b1;
            wdata <= 8'h00;
            data_o <= 8'h00;
            data_oe <= 1'b0;
            cycle_start <= 1'b0;
        end else begin
            cycle_start <= e_falls;
            data_oe <= next_oe;
            data_o <= wdata;
            if (e_falls) begin
                seq <= start_seq;
                hold_addr <= next_addr;
                addr_o <= start_addr;
                rw_o <= start_rw;
                wdata <= next_wdata;
            end
        end
    end

    // Read data is taken at the close of the high half, from the synchronised pins
    logic read_done;
    assign read_done = e_falls & rw_o;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= read_done;
            if (read_done) begin
                rdata <= din_s2;
            end
        end
    end

    // Reset pin is sampled on E falling edges; E itself keeps running meanwhile
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_reset <= 1'b1;
        end else if (e_falls) begin
            cpu_reset <= take_reset;
        end
    end

    // Timer and cycle count advance once per enable cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tk.timer_tick <= 1'b0;
            timer_tick <= 1'b0;
            ecycle_count <= 16'h0000;
        end else begin
            tk.timer_tick <= e_rises;
            timer_tick <= e_rises;
            if (e_rises) begin
                ecycle_count <= ecycle_count + 16'h0001;
            end
        end
    end

    // The bit-rate divider sees timer ticks only, never the oscillator
    bcg_baud #(
        .BAUD_DIV(BAUD_DIV)
    ) u_baud (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tk(tk.baud)
    );

    // Baud tick is a flop inside the divider, passed out without logic
    assign baud_tick = tk.baud_tick;
endmodule // bcg_clkgen

// ==== rtl/bcg_pkg.sv ====
package bcg_pkg;
    // Bus sequencer states
    typedef enum logic [0:0] {
        BCG_NORMAL = 1'b0,
        BCG_RMW_WR = 1'b1
    } bcg_seq_t;
endpackage

// ==== rtl/bcg_tick_if.sv ====
interface bcg_tick_if;
    logic timer_tick;
    logic baud_tick;
    modport src (output timer_tick, input baud_tick);
    modport baud (input timer_tick, output baud_tick);
endinterface
